// ### hdl/rid_pkg.sv
// Purpose: shared constants and types for the instruction decode block
// Assumes: 14-bit instruction words, 8-bit data path
// Notes: field positions and phase count live here
package rid_pkg;
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int K8_W = 8;
	localparam int K11_W = 11;
	localparam int BITNUM_W = 3;
	// field positions
	localparam int OPC_HI = 13;
	localparam int OPC_LO = 8;
	localparam int DEST_POS = 7;
	localparam int FADDR_HI = 6;
	localparam int BITNUM_HI = 9;
	localparam int BITNUM_LO = 7;
	localparam int K8_HI = 7;
	localparam int K11_HI = 10;
	// status bit positions
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam logic [6:0] STATUS_ADDR = 7'h03;
	localparam logic [6:0] PCL_ADDR = 7'h02;
	// timing
	localparam int PHASES = 4;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic [13:0] NOP_WORD = 14'h0000;

	typedef enum logic [1:0] {
		RID_CAT_BYTE = 2'b00,
		RID_CAT_BIT = 2'b01,
		RID_CAT_CALLJMP = 2'b10,
		RID_CAT_LIT = 2'b11
	} rid_cat_t;

	typedef enum logic [1:0] {
		RID_Q1 = 2'b00,
		RID_Q2 = 2'b01,
		RID_Q3 = 2'b10,
		RID_Q4 = 2'b11
	} rid_phase_t;

	typedef struct packed {
		rid_cat_t cat;
		logic [5:0] opc;
		logic dest;
		logic [6:0] faddr;
		logic [2:0] bitnum;
		logic [7:0] k8;
		logic [10:0] k11;
	} rid_fields_t;

	typedef struct packed {
		logic we;
		logic [6:0] addr;
		logic [7:0] data;
	} rid_fwrite_t;
endpackage : rid_pkg

// ### hdl/rid_phase_gen.sv
// Purpose: four-phase sequencer, one phase per oscillator period while clk_en is high
// Assumes: ref_clk is the oscillator clock
// Notes: cyc_end pulses in the last phase
`timescale 1ns/1ps
`default_nettype none
module rid_phase_gen (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	output rid_pkg::rid_phase_t phase,
	output logic cyc_end
);
	rid_pkg::rid_phase_t phase_r;
	rid_pkg::rid_phase_t phase_nxt;

	always_comb begin
		case (phase_r)
			rid_pkg::RID_Q1: phase_nxt = rid_pkg::RID_Q2;
			rid_pkg::RID_Q2: phase_nxt = rid_pkg::RID_Q3;
			rid_pkg::RID_Q3: phase_nxt = rid_pkg::RID_Q4;
			rid_pkg::RID_Q4: phase_nxt = rid_pkg::RID_Q1;
			default: phase_nxt = rid_pkg::RID_Q1;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_r <= rid_pkg::RID_Q1;
		end else if (clk_en) begin
			phase_r <= phase_nxt;
		end
	end

	assign phase = phase_r;
	assign cyc_end = clk_en && (phase_r == rid_pkg::RID_Q4);

	chk_phase_wrap: assert property (@(posedge ref_clk) disable iff (rst)
		(clk_en && phase_r == rid_pkg::RID_Q1) ##1 clk_en[*3] |=> phase_r == rid_pkg::RID_Q1)
		else $error("phase did not wrap after four periods");
endmodule : rid_phase_gen
`default_nettype wire

// ### hdl/rid_decode.sv
// Purpose: instruction decode and execute timing for an 8-bit core
// Assumes: fetched word and file read data valid through the cycle
// Notes: second cycle of taken branches and true skips runs as nop
`timescale 1ns/1ps
`default_nettype none
module rid_decode (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [13:0] instr,
	input wire logic [7:0] f_rdata,
	output logic [6:0] f_raddr,
	output rid_pkg::rid_fwrite_t f_wr,
	output logic [7:0] w_out,
	output logic [7:0] status_out,
	output logic [10:0] pc_out,
	output logic fetch_next,
	output logic flush_cycle,
	output rid_pkg::rid_phase_t phase
);
	rid_pkg::rid_fields_t fld;
	logic cyc_end;
	logic [7:0] w_r;
	logic [7:0] status_r;
	logic [10:0] pc_r;
	logic flush_r;
	rid_pkg::rid_fwrite_t f_wr_r;
	logic [7:0] res;
	logic [2:0] flg;
	logic [2:0] flg_mask;
	logic to_file;
	logic to_w;
	logic skip;
	logic jump;
	logic [3:0] lo_sum;
	logic [8:0] sum9;

	// ==========================================
	// phase sequencer
	rid_phase_gen u_phase (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.phase(phase),
		.cyc_end(cyc_end)
	);

	// ==========================================
	// field split
	function automatic rid_pkg::rid_cat_t cat_of(input logic [13:0] iw);
		case (iw[13:12])
			2'b00: cat_of = rid_pkg::RID_CAT_BYTE;
			2'b01: cat_of = rid_pkg::RID_CAT_BIT;
			2'b10: cat_of = rid_pkg::RID_CAT_CALLJMP;
			default: cat_of = rid_pkg::RID_CAT_LIT;
		endcase
	endfunction : cat_of

	function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b, input logic ci);
		add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
	endfunction : add9

	always_comb begin
		fld.cat = cat_of(instr);
		fld.opc = instr[rid_pkg::OPC_HI:rid_pkg::OPC_LO];
		fld.dest = instr[rid_pkg::DEST_POS];
		fld.faddr = instr[rid_pkg::FADDR_HI:0];
		fld.bitnum = instr[rid_pkg::BITNUM_HI:rid_pkg::BITNUM_LO];
		fld.k8 = instr[rid_pkg::K8_HI:0];
		fld.k11 = instr[rid_pkg::K11_HI:0];
	end

	assign f_raddr = fld.faddr;

	// ==========================================
	// execute
	always_comb begin
		res = 8'h00;
		flg = status_r[2:0];
		flg_mask = 3'b000;
		to_file = 1'b0;
		to_w = 1'b0;
		skip = 1'b0;
		jump = 1'b0;
		lo_sum = 4'h0;
		sum9 = 9'h000;
		case (fld.cat)
			rid_pkg::RID_CAT_BYTE: begin
				to_file = fld.dest;
				to_w = ~fld.dest;
				case (fld.opc[3:0])
					4'h0: begin
						res = w_r;
						to_file = fld.dest;
						to_w = 1'b0;
					end
					4'h1: begin
						res = 8'h00;
						flg_mask[rid_pkg::ST_Z] = 1'b1;
					end
					4'h2: begin
						sum9 = add9(f_rdata, ~w_r, 1'b1);
						lo_sum = 4'(({1'b0, f_rdata[3:0]} + {1'b0, ~w_r[3:0]} + 5'h01) >> 4);
						res = sum9[7:0];
						flg[rid_pkg::ST_C] = sum9[8];
						flg[rid_pkg::ST_DC] = lo_sum[0];
						flg_mask = 3'b111;
					end
					4'h3: begin
						res = f_rdata - 8'h01;
						flg_mask[rid_pkg::ST_Z] = 1'b1;
					end
					4'h4: begin
						res = f_rdata | w_r;
						flg_mask[rid_pkg::ST_Z] = 1'b1;
					end
					4'h5: begin
						res = f_rdata & w_r;
						flg_mask[rid_pkg::ST_Z] = 1'b1;
					end
					4'h6: begin
						res = f_rdata ^ w_r;
						flg_mask[rid_pkg::ST_Z] = 1'b1;
					end
					4'h7: begin
						sum9 = add9(f_rdata, w_r, 1'b0);
						lo_sum = 4'(({1'b0, f_rdata[3:0]} + {1'b0, w_r[3:0]}) >> 4);
						res = sum9[7:0];
						flg[rid_pkg::ST_C] = sum9[8];
						flg[rid_pkg::ST_DC] = lo_sum[0];
						flg_mask = 3'b111;
					end
					4'h8: begin
						res = f_rdata;
						flg_mask[rid_pkg::ST_Z] = 1'b1;
					end
					4'h9: begin
						res = ~f_rdata;
						flg_mask[rid_pkg::ST_Z] = 1'b1;
					end
					4'ha: begin
						res = f_rdata + 8'h01;
						flg_mask[rid_pkg::ST_Z] = 1'b1;
					end
					4'hb: begin
						res = f_rdata - 8'h01;
						skip = (res == 8'h00);
					end
					4'hc: begin
						res = {status_r[rid_pkg::ST_C], f_rdata[7:1]};
						flg[rid_pkg::ST_C] = f_rdata[0];
						flg_mask[rid_pkg::ST_C] = 1'b1;
					end
					4'hd: begin
						res = {f_rdata[6:0], status_r[rid_pkg::ST_C]};
						flg[rid_pkg::ST_C] = f_rdata[7];
						flg_mask[rid_pkg::ST_C] = 1'b1;
					end
					4'he: res = {f_rdata[3:0], f_rdata[7:4]};
					4'hf: begin
						res = f_rdata + 8'h01;
						skip = (res == 8'h00);
					end
					default: res = 8'h00;
				endcase
				flg[rid_pkg::ST_Z] = (res == 8'h00);
			end
			rid_pkg::RID_CAT_BIT: begin
				res = f_rdata;
				case (fld.opc[3:2])
					2'b00: begin
						res[fld.bitnum] = 1'b0;
						to_file = 1'b1;
					end
					2'b01: begin
						res[fld.bitnum] = 1'b1;
						to_file = 1'b1;
					end
					2'b10: skip = ~f_rdata[fld.bitnum];
					default: skip = f_rdata[fld.bitnum];
				endcase
			end
			rid_pkg::RID_CAT_CALLJMP: begin
				jump = 1'b1;
			end
			default: begin
				to_w = 1'b1;
				case (fld.opc[5:2])
					4'hc: res = fld.k8;
					4'hd: begin
						res = fld.k8;
						jump = 1'b1;
					end
					4'he: begin
						res = w_r | fld.k8;
						flg_mask[rid_pkg::ST_Z] = 1'b1;
						if (fld.opc[1:0] == 2'b01) begin
							res = w_r & fld.k8;
						end else if (fld.opc[1:0] == 2'b10) begin
							res = w_r ^ fld.k8;
						end
					end
					default: begin
						sum9 = fld.opc[1] ? add9(w_r, fld.k8, 1'b0) : add9(fld.k8, ~w_r, 1'b1);
						lo_sum = fld.opc[1] ? 4'(({1'b0, w_r[3:0]} + {1'b0, fld.k8[3:0]}) >> 4)
							: 4'(({1'b0, fld.k8[3:0]} + {1'b0, ~w_r[3:0]} + 5'h01) >> 4);
						res = sum9[7:0];
						flg[rid_pkg::ST_C] = sum9[8];
						flg[rid_pkg::ST_DC] = lo_sum[0];
						flg_mask = 3'b111;
					end
				endcase
				flg[rid_pkg::ST_Z] = (res == 8'h00);
			end
		endcase
		if (to_file && fld.faddr == rid_pkg::PCL_ADDR) begin
			jump = 1'b1;
		end
	end

	// ==========================================
	// state update in last phase
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			w_r <= rid_pkg::W_RESET;
		end else if (cyc_end && !flush_r && to_w) begin
			w_r <= res;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			f_wr_r <= '0;
		end else if (clk_en) begin
			f_wr_r.we <= (phase == rid_pkg::RID_Q3) && !flush_r && to_file;
			f_wr_r.addr <= fld.faddr;
			f_wr_r.data <= res;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			status_r <= 8'h00;
		end else if (cyc_end && !flush_r) begin
			if (to_file && fld.faddr == rid_pkg::STATUS_ADDR) begin
				status_r <= {res[7:3], (res[2:0] & ~flg_mask) | (flg & flg_mask)};
			end else begin
				status_r[2:0] <= (status_r[2:0] & ~flg_mask) | (flg & flg_mask);
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pc_r <= 11'h000;
			flush_r <= 1'b0;
		end else if (cyc_end) begin
			// two cycles on skip or jump
			flush_r <= !flush_r && (skip || jump);
			if (!flush_r && fld.cat == rid_pkg::RID_CAT_CALLJMP) begin
				pc_r <= fld.k11;
			end else if (!flush_r && to_file && fld.faddr == rid_pkg::PCL_ADDR) begin
				pc_r <= {pc_r[10:8], res};
			end else begin
				pc_r <= pc_r + 11'h001;
			end
		end
	end

	assign w_out = w_r;
	assign status_out = status_r;
	assign pc_out = pc_r;
	assign f_wr = f_wr_r;
	assign fetch_next = cyc_end;
	assign flush_cycle = flush_r;

	chk_flush_no_write: assert property (@(posedge ref_clk) disable iff (rst)
		flush_r |=> !f_wr_r.we)
		else $error("file written during nop cycle");
	chk_skip_flush: assert property (@(posedge ref_clk) disable iff (rst)
		(cyc_end && !flush_r && skip) |=> flush_r)
		else $error("skip did not insert nop cycle");
	chk_single_cycle: assert property (@(posedge ref_clk) disable iff (rst)
		(cyc_end && !flush_r && !skip && !jump) |=> !flush_r)
		else $error("plain op took two cycles");
	chk_w_dest: assert property (@(posedge ref_clk) disable iff (rst)
		(cyc_end && !flush_r && fld.cat == rid_pkg::RID_CAT_BYTE && !fld.dest && fld.opc[3:0] != 4'h0)
		|=> w_r == $past(res))
		else $error("accumulator not written");
	// write strobe only in last phase
	chk_write_phase: assert property (@(posedge ref_clk) disable iff (rst)
		f_wr_r.we |-> phase == rid_pkg::RID_Q4)
		else $error("file write outside last phase");
	chk_clr_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(cyc_end && !flush_r && fld.cat == rid_pkg::RID_CAT_BYTE && fld.opc[3:0] == 4'h1)
		|=> status_r[rid_pkg::ST_Z])
		else $error("zero flag not set on clear");
	// bit op changes only one bit
	chk_bit_rmw: assert property (@(posedge ref_clk) disable iff (rst)
		(clk_en && phase == rid_pkg::RID_Q3 && !flush_r && fld.cat == rid_pkg::RID_CAT_BIT && !fld.opc[3])
		|=> $countones(f_wr_r.data ^ $past(f_rdata)) <= 1)
		else $error("bit op altered other bits");
	chk_jump_pc: assert property (@(posedge ref_clk) disable iff (rst)
		(cyc_end && !flush_r && fld.cat == rid_pkg::RID_CAT_CALLJMP) |=> pc_r == $past(fld.k11))
		else $error("pc not loaded from literal");
endmodule : rid_decode
`default_nettype wire

// ### test/rid_mem_model.sv
// Purpose: program store and file register space beside the decoder
// Assumes: word at pc_out is fetched combinationally
// Notes: bench preloads both arrays by hierarchy
`timescale 1ns/1ps
`default_nettype none
module rid_mem_model (
	input wire logic ref_clk,
	input wire logic [10:0] pc_out,
	input wire logic [6:0] f_raddr,
	input wire rid_pkg::rid_fwrite_t f_wr,
	output logic [13:0] instr,
	output logic [7:0] f_rdata
);
	// program store holds no legacy loads
	logic [13:0] prog [0:2047];
	logic [7:0] fmem [0:127];
	assign instr = prog[pc_out];
	assign f_rdata = fmem[f_raddr];
	always @(posedge ref_clk) begin
		if (f_wr.we === 1'b1) begin
			fmem[f_wr.addr] <= f_wr.data;
		end
	end
endmodule : rid_mem_model
`default_nettype wire

// ### test/testbench.sv
// Purpose: directed scenarios for the instruction decoder
// Assumes: one instruction per fetch_next pulse
// Notes: each scenario restarts the core from reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk, rst, clk_en;
	logic [13:0] instr;
	logic [7:0] f_rdata, w_out, status_out;
	logic [6:0] f_raddr;
	rid_pkg::rid_fwrite_t f_wr;
	logic [10:0] pc_out;
	logic fetch_next, flush_cycle;
	rid_pkg::rid_phase_t phase;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;

	rid_decode rid_decode_i (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .instr(instr),
		.f_rdata(f_rdata), .f_raddr(f_raddr), .f_wr(f_wr), .w_out(w_out), .status_out(status_out),
		.pc_out(pc_out), .fetch_next(fetch_next), .flush_cycle(flush_cycle), .phase(phase));
	rid_mem_model rid_mem_model_i (.ref_clk(ref_clk), .pc_out(pc_out), .f_raddr(f_raddr),
		.f_wr(f_wr), .instr(instr), .f_rdata(f_rdata));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task conclude;
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			conclude();
		end
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task restart;
		rst = 1'b1;
		clk_en = 1'b1;
		foreach (rid_mem_model_i.prog[i]) rid_mem_model_i.prog[i] = 14'h0000;
		repeat (10) @(posedge ref_clk);
		#1 rst = 1'b0;
	endtask : restart

	// one instruction cycle, ends just after its last edge
	task automatic step;
		int cnt;
		cnt = 0;
		do begin
			@(negedge ref_clk);
			cnt++;
		end while (fetch_next !== 1'b1 && cnt < 20);
		@(posedge ref_clk);
		#1;
		check(16'(cnt), 16'h0004);
	endtask : step

	task t_literal;
		restart();
		clk_en = 1'b0;
		repeat (8) @(posedge ref_clk);
		#1;
		check(16'(phase), 16'(rid_pkg::RID_Q1));
		check(16'(pc_out), 16'h0000);
		clk_en = 1'b1;
		rid_mem_model_i.prog[0] = 14'h3e05;
		// don't-care bit set on purpose
		rid_mem_model_i.prog[1] = 14'h3f05;
		rid_mem_model_i.prog[2] = 14'h390e;
		rid_mem_model_i.prog[3] = 14'h3eff;
		step();
		check(16'(w_out), 16'h0005);
		check(16'(pc_out), 16'h0001);
		step();
		check(16'(w_out), 16'h000a);
		step();
		check(16'(w_out), 16'h000a);
		step();
		check(16'(w_out), 16'h0009);
		check(16'(status_out[2:0]), 16'h0003);
		check(16'(flush_cycle), 16'h0000);
	endtask : t_literal

	task t_byte;
		restart();
		rid_mem_model_i.fmem[32] = 8'h11;
		rid_mem_model_i.prog[0] = 14'h3e0a;
		rid_mem_model_i.prog[1] = 14'h0720;
		rid_mem_model_i.prog[2] = 14'h07a0;
		rid_mem_model_i.prog[3] = 14'h00ff;
		step();
		step();
		check(16'(w_out), 16'h001b);
		check(16'(rid_mem_model_i.fmem[32]), 16'h0011);
		step();
		check(16'(rid_mem_model_i.fmem[32]), 16'h002c);
		check(16'(w_out), 16'h001b);
		step();
		check(16'(rid_mem_model_i.fmem[127]), 16'h001b);
	endtask : t_byte

	task t_bit;
		restart();
		rid_mem_model_i.fmem[64] = 8'ha5;
		rid_mem_model_i.prog[0] = 14'h14c0;
		rid_mem_model_i.prog[1] = 14'h13c0;
		rid_mem_model_i.prog[2] = 14'h1c40;
		rid_mem_model_i.prog[3] = 14'h3e01;
		rid_mem_model_i.prog[4] = 14'h1dc0;
		rid_mem_model_i.prog[5] = 14'h3e01;
		step();
		check(16'(rid_mem_model_i.fmem[64]), 16'h00a7);
		step();
		check(16'(rid_mem_model_i.fmem[64]), 16'h0027);
		step();
		check(16'(flush_cycle), 16'h0001);
		step();
		check(16'(flush_cycle), 16'h0000);
		check(16'(w_out), 16'h0000);
		step();
		check(16'(flush_cycle), 16'h0000);
		step();
		check(16'(w_out), 16'h0001);
	endtask : t_bit

	task t_jump_status;
		restart();
		rid_mem_model_i.prog[0] = 14'h0183;
		rid_mem_model_i.prog[1] = 14'h2923;
		step();
		check(16'(status_out), 16'h0004);
		step();
		check(16'(pc_out), 16'h0123);
		check(16'(flush_cycle), 16'h0001);
		step();
		check(16'(flush_cycle), 16'h0000);
	endtask : t_jump_status

	initial begin
		rst = 1'b1;
		clk_en = 1'b0;
		t_literal();
		t_byte();
		t_bit();
		t_jump_status();
		conclude();
	end
endmodule : testbench
`default_nettype wire
